// ### adc_trigger_scan_sequencer_tb.sv
`timescale 1ns/1ns
module adc_trigger_scan_sequencer_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic cm_wr = 1'b0, tm_wr = 1'b0, cs_wr = 1'b0, rd = 1'b0, t0 = 1'b0, t1 = 1'b0;
  logic [7:0] wd = 8'h00;
  logic cmp_ge, sample_en, comp_en, busy, irq;
  logic [9:0] trial;
  logic [4:0] mux;
  logic [7:0] cm_reg, tm_reg, cs_reg, r8;
  logic [15:0] r16;
  int err_count = 0;
  int num_checks = 0;

  atss_seq dut (.clk(clk), .rst_n(rst_n), .ce(ce), .conv_mode_wr(cm_wr),
    .conv_mode_wdata(wd), .trigger_mode_wr(tm_wr), .trigger_mode_wdata(wd),
    .channel_select_wr(cs_wr), .channel_select_wdata(wd), .result_rd(rd),
    .timer_trig0(t0), .timer_trig1(t1), .cmp_ge(cmp_ge), .dac_trial(trial),
    .sample_en(sample_en), .mux_channel(mux), .comparator_en(comp_en),
    .conv_mode_reg(cm_reg), .trigger_mode_reg(tm_reg), .channel_select_reg(cs_reg),
    .result_reg_16(r16), .result_reg_8(r8), .busy(busy), .conv_done_irq(irq));
  atss_afe_model afe (.clk(clk), .dac_trial(trial), .sample_en(sample_en),
    .mux_channel(mux), .cmp_ge(cmp_ge));

  initial
  begin
    forever #50 clk = ~clk;
  end

  function automatic logic [9:0] lv(input logic [4:0] ch);
    return {ch, 5'h15};
  endfunction : lv

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // sel: 0 mode, 1 trigger mode, 2 channel select
  task automatic wr(input int sel, input logic [7:0] d);
    @(posedge clk);
    cm_wr <= (sel == 0);
    tm_wr <= (sel == 1);
    cs_wr <= (sel == 2);
    wd <= d;
    @(posedge clk);
    cm_wr <= 1'b0;
    tm_wr <= 1'b0;
    cs_wr <= 1'b0;
  endtask : wr

  // w: 0 result read, 1 timer 0, 2 timer 1
  task automatic pulse(input int w);
    @(posedge clk);
    rd <= (w == 0);
    t0 <= (w == 1);
    t1 <= (w == 2);
    @(posedge clk);
    rd <= 1'b0;
    t0 <= 1'b0;
    t1 <= 1'b0;
  endtask : pulse

  task automatic wait_irq(input int lim, input logic want, input logic [9:0] code);
    int i;
    for (i = 0; i < lim && irq !== 1'b1; i++)
      @(negedge clk);
    check(irq, want);
    if (want)
      check(r16, {code, 6'h00});
    if (want && i == lim)
      print_verdict();
    @(negedge clk);
  endtask : wait_irq

  task automatic sel_sw;
    wr(2, 8'h03);
    wr(0, 8'h01);
    repeat (10) @(posedge clk);
    wr(0, 8'h81);
    ce <= 1'b0;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    wait_irq(200, 1'b1, lv(5'h03));
    pulse(0);
    wait_irq(200, 1'b1, lv(5'h03));
    wr(2, 8'h45);
    wait_irq(200, 1'b1, lv(5'h15));
    wr(0, 8'h01);
    wait_irq(80, 1'b0, 10'h000);
  endtask : sel_sw

  task automatic scan_sw;
    int s;
    wr(2, 8'h02);
    wr(0, 8'hc1);
    for (s = 0; s < 2; s++)
      wait_irq(200, 1'b1, lv(5'(2 + s)));
    // rewrite mid scan goes back to the first slot
    wr(2, 8'h02);
    for (s = 0; s < 5; s++)
      wait_irq(200, 1'b1, lv(5'(2 + s % 4)));
    wr(0, 8'h01);
  endtask : scan_sw

  task automatic timer_hw;
    wr(2, 8'h01);
    wr(1, 8'h81);
    @(negedge clk);
    check({8'h00, tm_reg}, 16'h0081);
    wr(0, 8'h81);
    pulse(1);
    wait_irq(80, 1'b0, 10'h000);
    pulse(2);
    repeat (10) @(posedge clk);
    pulse(2);
    wait_irq(200, 1'b1, lv(5'h01));
    wr(0, 8'hc1);
    pulse(2);
    wait_irq(200, 1'b1, lv(5'h01));
    wait_irq(200, 1'b1, lv(5'h02));
    wr(0, 8'h01);
    wr(0, 8'h00);
    wr(1, 8'h00);
    ce <= 1'b0;
  endtask : timer_hw

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    sel_sw();
    scan_sw();
    timer_hw();
    print_verdict();
  end
endmodule : adc_trigger_scan_sequencer_tb

// ### atss_afe_model.sv
`timescale 1ns/1ns
module atss_afe_model
(
  // analog side
  input wire logic clk,
  input wire logic [9:0] dac_trial,
  input wire logic sample_en,
  input wire logic [4:0] mux_channel,
  output logic cmp_ge
);
  // distinct level per input so a wrong mux shows in the code
  logic [9:0] held = 10'h3ff;
  always @(posedge clk)
    if (sample_en)
      held <= {mux_channel, 5'h15};
  assign cmp_ge = held >= dac_trial;
endmodule : atss_afe_model

// ### atss_pkg.sv
package atss_pkg;
  // conversion mode register fields
  localparam int CM_COMP_EN_BIT = 0;
  localparam int CM_TIME_LSB = 1;
  localparam int CM_TIME_W = 5;
  localparam int CM_SCAN_BIT = 6;
  localparam int CM_START_BIT = 7;
  // trigger mode register fields
  localparam int TM_SRC_BIT = 0;
  localparam int TM_HW_BIT = 7;
  // channel select register fields
  localparam int CS_CH_W = 4;
  localparam int CS_AMP_BIT = 6;
  // conversion geometry
  localparam int RES_BITS = 10;
  localparam int SLOT_W = 2;
  localparam int SLOTS = 4;
  localparam int CH_W = 5;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 2'h3;
  // sampling takes 8 clocks plus 4 per conversion time step, then one clock per approximation bit
  localparam logic [7:0] SAMPLE_CYCLES = 8'h08;
  localparam logic [7:0] TIME_STEP_CYCLES = 8'h04;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam int RESULT_SHIFT = 6;

  typedef enum logic [1:0]
  {
    ATSS_IDLE = 2'b00,
    ATSS_WAIT_TRIG = 2'b01,
    ATSS_SAMPLE = 2'b10,
    ATSS_APPROX = 2'b11
  } atss_state_t;
endpackage : atss_pkg

// ### atss_sar_core.sv
`timescale 1ns/1ns
// successive approximation engine: one bit decided per enabled cycle
module atss_sar_core
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire logic start,
  input wire logic abort,
  // comparator: high when sampled voltage >= trial tap
  input wire logic cmp_ge,
  output logic [atss_pkg::RES_BITS-1:0] trial,
  // result
  output logic done,
  output logic [atss_pkg::RES_BITS-1:0] code
);
  logic [atss_pkg::RES_BITS-1:0] sar_q, sar_d;
  logic [atss_pkg::RES_BITS-1:0] bit_q, bit_d;
  logic done_q, done_d;
  logic [atss_pkg::RES_BITS-1:0] trial_q, trial_d;

  always_comb
  begin
    sar_d = sar_q;
    bit_d = bit_q;
    done_d = 1'b0;
    if (abort)
    begin
      bit_d = '0;
    end
    else if (start)
    begin
      sar_d = '0;
      bit_d = {1'b1, {(atss_pkg::RES_BITS-1){1'b0}}};
    end
    else if (bit_q != '0)
    begin
      if (cmp_ge)
      begin
        sar_d = sar_q | bit_q;
      end
      bit_d = bit_q >> 1;
      done_d = (bit_q[0] == 1'b1);
    end
    // registered tap matches the bit under test, so the comparator never lags
    trial_d = sar_d | bit_d;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sar_q <= '0;
      bit_q <= '0;
      done_q <= 1'b0;
      trial_q <= '0;
    end
    else if (ce)
    begin
      sar_q <= sar_d;
      bit_q <= bit_d;
      done_q <= done_d;
      trial_q <= trial_d;
    end
  end

  assign trial = trial_q;
  assign done = done_q;
  assign code = sar_q;
endmodule : atss_sar_core

// ### atss_seq.sv
`timescale 1ns/1ns
// Operation
// - software or timer start chosen by trigger_mode_reg
// - software start converts selected channel immediately
// - keep converting until start bit cleared
// - register write aborts, restart or slot 0
// - timer mode waits for selected timer trigger
// - timer trigger during conversion aborts, restarts
// - select mode converts one selected channel
// - select mode stores result, raises done irq
// - scan mode converts slots 0 to 3
// - scan stores every result, irq each one
// - all slots share one result register
// - scan continues to next slot untriggered
// - channel rewrite restarts, irq on finish
// - channel change to irq equals conversion time
// - each conversion yields a 10-bit code
// - result left-justified x64, 8-bit upper copy
// - result read delays update by one cycle
// - coinciding register write cancels store and irq
module atss_seq
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // register writes from the cpu side, same clock
  input wire logic conv_mode_wr,
  input wire logic [7:0] conv_mode_wdata,
  input wire logic trigger_mode_wr,
  input wire logic [7:0] trigger_mode_wdata,
  input wire logic channel_select_wr,
  input wire logic [7:0] channel_select_wdata,
  input wire logic result_rd,
  // timer trigger pulses from timers on the same clock
  input wire logic timer_trig0,
  input wire logic timer_trig1,
  // analog front end
  input wire logic cmp_ge,
  output logic [9:0] dac_trial,
  output logic sample_en,
  output logic [4:0] mux_channel,
  output logic comparator_en,
  // register contents and status
  output logic [7:0] conv_mode_reg,
  output logic [7:0] trigger_mode_reg,
  output logic [7:0] channel_select_reg,
  output logic [15:0] result_reg_16,
  output logic [7:0] result_reg_8,
  output logic busy,
  output logic conv_done_irq
);
  atss_pkg::atss_state_t st_q, st_d;
  logic [7:0] cm_q, cm_d, tm_q, tm_d, cs_q, cs_d;
  logic [1:0] slot_q, slot_d;
  logic [7:0] cnt_q, cnt_d;
  logic [15:0] res_q, res_d;
  logic [9:0] pend_q, pend_d;
  logic pend_v_q, pend_v_d;
  logic irq_q, irq_d;
  logic sample_q, sample_d;
  logic [4:0] mux_q, mux_d;
  logic sar_start, sar_abort, sar_done;
  logic [9:0] sar_code, sar_trial;
  logic reg_wr, start_bit, hw_mode, trig_hit;
  logic [9:0] store_code;
  logic store_now;

  // channel of a scan slot: the low four select bits name slot 0, slots follow it; only select mode uses the amp bit
  function automatic logic [4:0] slot_channel(input logic [7:0] sel, input logic [1:0] slot,
                                               input logic scan);
    logic [4:0] base;
    base = {sel[atss_pkg::CS_AMP_BIT], sel[atss_pkg::CS_CH_W-1:0]};
    if (scan)
      slot_channel = {1'b0, sel[atss_pkg::CS_CH_W-1:0] + {2'h0, slot}};
    else
      slot_channel = base;
  endfunction : slot_channel

  // sample length grows with the programmed conversion time
  function automatic logic [7:0] sample_len(input logic [7:0] mode);
    sample_len = atss_pkg::SAMPLE_CYCLES
      + 8'(mode[atss_pkg::CM_TIME_LSB +: atss_pkg::CM_TIME_W]) * atss_pkg::TIME_STEP_CYCLES;
  endfunction : sample_len

  assign reg_wr = conv_mode_wr | trigger_mode_wr | channel_select_wr;
  assign start_bit = cm_q[atss_pkg::CM_START_BIT];
  assign hw_mode = tm_q[atss_pkg::TM_HW_BIT];
  assign trig_hit = tm_q[atss_pkg::TM_SRC_BIT] ? timer_trig1 : timer_trig0;

  always_comb
  begin
    cm_d = conv_mode_wr ? conv_mode_wdata : cm_q;
    tm_d = trigger_mode_wr ? trigger_mode_wdata : tm_q;
    cs_d = channel_select_wr ? channel_select_wdata : cs_q;
    st_d = st_q;
    slot_d = slot_q;
    cnt_d = cnt_q;
    sar_start = 1'b0;
    sar_abort = 1'b0;
    irq_d = 1'b0;
    store_now = 1'b0;
    if (!cm_d[atss_pkg::CM_START_BIT])
    begin
      st_d = atss_pkg::ATSS_IDLE;
      sar_abort = 1'b1;
    end
    else if (reg_wr || (st_q == atss_pkg::ATSS_IDLE))
    begin
      // write aborts; restart at slot 0, timer mode waits again
      sar_abort = 1'b1;
      slot_d = 2'h0;
      cnt_d = sample_len(cm_d);
      st_d = tm_d[atss_pkg::TM_HW_BIT] ? atss_pkg::ATSS_WAIT_TRIG
                                       : atss_pkg::ATSS_SAMPLE;
    end
    else if (hw_mode && trig_hit)
    begin
      sar_abort = (st_q != atss_pkg::ATSS_WAIT_TRIG);
      slot_d = 2'h0;
      cnt_d = sample_len(cm_q);
      st_d = atss_pkg::ATSS_SAMPLE;
    end
    else
    begin
      unique case (st_q)
        atss_pkg::ATSS_IDLE, atss_pkg::ATSS_WAIT_TRIG:
        begin
          st_d = st_q;
        end
        atss_pkg::ATSS_SAMPLE:
        begin
          if (cnt_q <= 8'h01)
          begin
            sar_start = 1'b1;
            st_d = atss_pkg::ATSS_APPROX;
          end
          else
          begin
            cnt_d = cnt_q - 8'h01;
          end
        end
        atss_pkg::ATSS_APPROX:
        begin
          if (sar_done)
          begin
            store_now = 1'b1;
            irq_d = 1'b1;
            cnt_d = sample_len(cm_q);
            // scan moves on untriggered; repeat goes on without a new trigger
            st_d = atss_pkg::ATSS_SAMPLE;
            if (cm_q[atss_pkg::CM_SCAN_BIT])
              slot_d = (slot_q == atss_pkg::SLOT_LAST) ? 2'h0 : slot_q + 2'h1;
          end
        end
      endcase
    end
    // a pending result waits out a read, and a fresh one wins the slot
    store_code = store_now ? sar_code : pend_q;
    pend_v_d = (store_now | pend_v_q) & result_rd;
    pend_d = store_code;
    res_d = res_q;
    if ((store_now | pend_v_q) && !result_rd)
      res_d = {store_code, 6'h00};
    mux_d = slot_channel(cs_d, slot_d, cm_d[atss_pkg::CM_SCAN_BIT]);
    sample_d = (st_d == atss_pkg::ATSS_SAMPLE);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q <= atss_pkg::ATSS_IDLE;
      cm_q <= atss_pkg::REG_RESET;
      tm_q <= atss_pkg::REG_RESET;
      cs_q <= atss_pkg::REG_RESET;
      slot_q <= 2'h0;
      cnt_q <= 8'h00;
      res_q <= atss_pkg::RESULT_RESET;
      pend_q <= 10'h000;
      pend_v_q <= 1'b0;
      irq_q <= 1'b0;
      sample_q <= 1'b0;
      mux_q <= 5'h00;
    end
    else if (ce)
    begin
      st_q <= st_d;
      cm_q <= cm_d;
      tm_q <= tm_d;
      cs_q <= cs_d;
      slot_q <= slot_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      pend_q <= pend_d;
      pend_v_q <= pend_v_d;
      irq_q <= irq_d;
      sample_q <= sample_d;
      mux_q <= mux_d;
    end
  end

  atss_sar_core u_sar
  (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(sar_start),
    .abort(sar_abort),
    .cmp_ge(cmp_ge),
    .trial(sar_trial),
    .done(sar_done),
    .code(sar_code)
  );

  assign dac_trial = sar_trial;
  assign sample_en = sample_q;
  assign mux_channel = mux_q;
  assign comparator_en = cm_q[atss_pkg::CM_COMP_EN_BIT];
  assign conv_mode_reg = cm_q;
  assign trigger_mode_reg = tm_q;
  assign channel_select_reg = cs_q;
  assign result_reg_16 = res_q;
  assign result_reg_8 = res_q[15:8];
  assign busy = start_bit;
  assign conv_done_irq = irq_q;
endmodule : atss_seq

// ### atss_seq_sva.sv
`timescale 1ns/1ns
module atss_seq_sva
(
  // clock and cpu side
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic conv_mode_wr,
  input wire logic [7:0] conv_mode_wdata,
  input wire logic trigger_mode_wr,
  input wire logic channel_select_wr,
  input wire logic result_rd,
  // outputs watched
  input wire logic sample_en,
  input wire logic [4:0] mux_channel,
  input wire logic comparator_en,
  input wire logic [7:0] conv_mode_reg,
  input wire logic [7:0] channel_select_reg,
  input wire logic [15:0] result_reg_16,
  input wire logic [7:0] result_reg_8,
  input wire logic busy,
  input wire logic conv_done_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic any_wr;
  assign any_wr = ce && (conv_mode_wr || trigger_mode_wr || channel_select_wr);
  a_irq_spacing: assert property (conv_done_irq |=> !conv_done_irq [*8])
    else $error("completion pulses too close");
  a_write_quiet: assert property (any_wr |=> !conv_done_irq [*8])
    else $error("completion flagged right after a register write");
  a_idle_no_sample: assert property (!busy |-> !sample_en)
    else $error("sampling with start bit clear");
  a_mode_capture: assert property (ce && conv_mode_wr |=> conv_mode_reg == $past(conv_mode_wdata)
    && busy == conv_mode_reg[7] && comparator_en == conv_mode_reg[0])
    else $error("mode write not taken");
  a_result_pair: assert property (result_reg_8 == result_reg_16[15:8]
    && result_reg_16[5:0] == 6'h00)
    else $error("result halves disagree");
  // a store held off by a read lands one cycle after the read
  a_store_cause: assert property ($changed(result_reg_16) && !$past(result_rd, 2)
    |-> conv_done_irq)
    else $error("result changed without completion");
  a_sel_mux_ch: assert property (sample_en && !conv_mode_reg[6] && !$past(conv_mode_wr)
    && !$past(channel_select_wr) && !$past(channel_select_wr, 2)
    |-> mux_channel == {channel_select_reg[6], channel_select_reg[3:0]})
    else $error("select mode samples wrong input");
  a_freeze_hold: assert property (!ce |=> $stable(result_reg_16) && $stable(conv_mode_reg))
    else $error("state moved while disabled");
endmodule : atss_seq_sva

bind atss_seq atss_seq_sva u_sva (.clk(clk), .rst_n(rst_n), .ce(ce),
  .conv_mode_wr(conv_mode_wr), .conv_mode_wdata(conv_mode_wdata),
  .trigger_mode_wr(trigger_mode_wr), .channel_select_wr(channel_select_wr),
  .result_rd(result_rd), .sample_en(sample_en), .mux_channel(mux_channel),
  .comparator_en(comparator_en), .conv_mode_reg(conv_mode_reg),
  .channel_select_reg(channel_select_reg), .result_reg_16(result_reg_16),
  .result_reg_8(result_reg_8), .busy(busy), .conv_done_irq(conv_done_irq));
